// ### hw/edid_seq.sv
`timescale 1ns/100ps
`include "edid_seq_params.svh"
module edid_seq #(
    parameter int N = `CHANNELS,
    parameter int BYTES = `ID_BYTES,
    parameter int WR_WAIT = `EE_WRITE_CYC,
    parameter int QUARTER = `I2C_QUARTER_CYC
) (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic SDA_I,
    output logic SDA_OE,
    output logic SCL_OE,
    output logic ID_MUX_EN,
    output logic ID_MUX_TO_DISPLAY,
    output logic [$clog2(N)-1:0] ID_MUX_SEL,
    output logic [N-1:0] MODE_PROG,
    output logic [N-1:0] WP_OPEN,
    input wire logic [$clog2(N)-1:0] SEL_IN,
    input wire logic SEL_VALID,
    output logic [$clog2(N)-1:0] CHAN_SEL,
    output logic VIDEO_EN,
    input wire logic HPD_I,
    output logic [N-1:0] HPD_OUT,
    input wire logic TAMPER_I,
    input wire logic SELFTEST_FAIL_I,
    output logic REJECT_LED,
    output logic NORMAL
);
    initial begin
        if (N < 2) $error("N must be at least two channels");
        if (BYTES < `HDR_LEN || BYTES > 256) $error("BYTES must be 8 to 256");
        if ((BYTES & (BYTES - 1)) != 0) $error("BYTES must be a power of two");
        if (WR_WAIT < 1) $error("WR_WAIT must be at least one cycle");
    end

    localparam int CW = $clog2(N);
    localparam int IW = $clog2(BYTES + 1);
    edid_seq_pkg::seq_state_t state;
    logic [7:0] image [BYTES];
    logic [IW-1:0] idx;
    logic [CW-1:0] ch;
    logic [31:0] wcnt;
    logic verify, issued, programming, mism, hdr_ok;
    logic [7:0] sum;
    logic [2:0] tmp_m, tmp_s;
    logic tamper;
    edid_seq_pkg::i2c_cmd_t cmd;
    logic cmd_valid, cmd_ready, done;
    logic [7:0] rdata, hdr_exp;
    logic op_state, last_idx, sel_ok;

    // Pin synchronisers: tamper, self-test fail, display hot-plug
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            tmp_m <= 3'h0;
            tmp_s <= 3'h0;
        end else begin
            tmp_m <= {HPD_I, SELFTEST_FAIL_I, TAMPER_I};
            tmp_s <= tmp_m;
        end
    end

    // Tamper and self-test failure latch until reset
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) tamper <= 1'b0;
        else if (tmp_s[0] || tmp_s[1]) tamper <= 1'b1;
    end

    // Engine command selection per state
    assign op_state = (state != edid_seq_pkg::S_CHECK) && (state != edid_seq_pkg::S_HALT) &&
                      (state != edid_seq_pkg::S_WR_WAIT) && (state != edid_seq_pkg::S_NEXT) &&
                      (state != edid_seq_pkg::S_NORMAL);
    assign cmd_valid = op_state && !issued;
    assign last_idx = (idx == IW'(BYTES - 1));
    assign cmd.op = (state == edid_seq_pkg::S_RD_START || state == edid_seq_pkg::S_RD_RESTART ||
                     state == edid_seq_pkg::S_WR_START) ? edid_seq_pkg::OP_START :
                    (state == edid_seq_pkg::S_RD_STOP || state == edid_seq_pkg::S_WR_STOP) ?
                    edid_seq_pkg::OP_STOP :
                    (state == edid_seq_pkg::S_RD_DATA) ? edid_seq_pkg::OP_READ : edid_seq_pkg::OP_WRITE;
    assign cmd.data = (state == edid_seq_pkg::S_RD_DEVR) ? `ID_DEV_RD :
                      (state == edid_seq_pkg::S_RD_OFS) ? `ID_START_OFS :
                      (state == edid_seq_pkg::S_WR_OFS) ? 8'(idx) :
                      (state == edid_seq_pkg::S_WR_DATA) ? image[idx[IW-2:0]] : `ID_DEV_WR;
    assign cmd.ack = !last_idx;
    assign hdr_exp = (idx == '0 || idx == IW'(`HDR_LEN - 1)) ? `HDR_EDGE : `HDR_MID;
    assign sel_ok = SEL_VALID && (SEL_IN < CW'(N - 1) || SEL_IN == CW'(N - 1));

    // One I2C master shared by the display and all EEPROMs via the mux
    i2c_op_engine #(.QUARTER(QUARTER)) u_eng (
        .clk(CLK),
        .rst_n(RST_N),
        .cmd(cmd),
        .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready),
        .done(done),
        .rdata(rdata),
        .nack(),
        .sda_i(SDA_I),
        .sda_oe(SDA_OE),
        .scl_oe(SCL_OE)
    );

    // Sequencer: capture, validate, program and verify each channel, run
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            state <= edid_seq_pkg::S_RD_START;
            idx <= '0;
            ch <= '0;
            wcnt <= '0;
            verify <= 1'b0;
            issued <= 1'b0;
            programming <= 1'b0;
            mism <= 1'b0;
            hdr_ok <= 1'b1;
            sum <= 8'h00;
        end else begin
            if (cmd_valid && cmd_ready) issued <= 1'b1;
            if (done) issued <= 1'b0;
            case (state)
                edid_seq_pkg::S_RD_START: if (done) state <= edid_seq_pkg::S_RD_DEVW;
                edid_seq_pkg::S_RD_DEVW: if (done) state <= edid_seq_pkg::S_RD_OFS;
                edid_seq_pkg::S_RD_OFS: if (done) state <= edid_seq_pkg::S_RD_RESTART;
                edid_seq_pkg::S_RD_RESTART: if (done) state <= edid_seq_pkg::S_RD_DEVR;
                edid_seq_pkg::S_RD_DEVR: begin
                    if (done) begin
                        idx <= '0;
                        state <= edid_seq_pkg::S_RD_DATA;
                    end
                end
                edid_seq_pkg::S_RD_DATA: begin
                    if (done) begin
                        if (!verify) begin
                            sum <= sum + rdata;
                            if (idx < IW'(`HDR_LEN) && rdata != hdr_exp) hdr_ok <= 1'b0;
                        end else if (rdata != image[idx[IW-2:0]]) begin
                            mism <= 1'b1;
                        end
                        idx <= idx + IW'(1);
                        if (last_idx) state <= edid_seq_pkg::S_RD_STOP;
                    end
                end
                edid_seq_pkg::S_RD_STOP: begin
                    if (done) begin
                        idx <= '0;
                        if (!verify) state <= edid_seq_pkg::S_CHECK;
                        else if (mism) state <= edid_seq_pkg::S_WR_START;
                        else state <= edid_seq_pkg::S_NEXT;
                    end
                end
                edid_seq_pkg::S_CHECK: begin
                    if (hdr_ok && sum == 8'h00) begin
                        programming <= 1'b1;
                        state <= edid_seq_pkg::S_WR_START;
                    end else begin
                        state <= edid_seq_pkg::S_HALT;
                    end
                end
                edid_seq_pkg::S_HALT: state <= edid_seq_pkg::S_HALT;
                edid_seq_pkg::S_WR_START: begin
                    mism <= 1'b0;
                    verify <= 1'b1;
                    if (done) state <= edid_seq_pkg::S_WR_DEVW;
                end
                edid_seq_pkg::S_WR_DEVW: if (done) state <= edid_seq_pkg::S_WR_OFS;
                edid_seq_pkg::S_WR_OFS: if (done) state <= edid_seq_pkg::S_WR_DATA;
                edid_seq_pkg::S_WR_DATA: if (done) state <= edid_seq_pkg::S_WR_STOP;
                edid_seq_pkg::S_WR_STOP: begin
                    if (done) begin
                        wcnt <= '0;
                        state <= edid_seq_pkg::S_WR_WAIT;
                    end
                end
                edid_seq_pkg::S_WR_WAIT: begin
                    wcnt <= wcnt + 32'd1;
                    if (wcnt == 32'(WR_WAIT - 1)) begin
                        idx <= idx + IW'(1);
                        state <= last_idx ? edid_seq_pkg::S_RD_START : edid_seq_pkg::S_WR_START;
                    end
                end
                edid_seq_pkg::S_NEXT: begin
                    if (ch == CW'(N - 1)) begin
                        programming <= 1'b0;
                        state <= edid_seq_pkg::S_NORMAL;
                    end else begin
                        ch <= ch + CW'(1);
                        state <= edid_seq_pkg::S_WR_START;
                    end
                end
                edid_seq_pkg::S_NORMAL: state <= edid_seq_pkg::S_NORMAL;
                default: state <= edid_seq_pkg::S_HALT;
            endcase
        end
    end

    // Captured image storage, written only during the one capture
    always_ff @(posedge CLK) begin
        if (state == edid_seq_pkg::S_RD_DATA && done && !verify) image[idx[IW-2:0]] <= rdata;
    end

    // Identification path switches decoded straight from sequencer flops
    assign ID_MUX_EN = (state != edid_seq_pkg::S_NORMAL) && (state != edid_seq_pkg::S_HALT);
    assign ID_MUX_TO_DISPLAY = !programming;
    assign ID_MUX_SEL = ch;
    assign MODE_PROG = programming ? (N'(1) << ch) : '0;
    assign WP_OPEN = programming ? (N'(1) << ch) : '0;

    // Normal mode outputs: selection, video enable, hot-plug, indicator
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            CHAN_SEL <= '0;
            VIDEO_EN <= 1'b0;
            HPD_OUT <= '0;
            REJECT_LED <= 1'b0;
            NORMAL <= 1'b0;
        end else begin
            if (state == edid_seq_pkg::S_NORMAL && sel_ok) CHAN_SEL <= SEL_IN;
            VIDEO_EN <= (state == edid_seq_pkg::S_NORMAL) && !tamper && !tmp_s[0] && !tmp_s[1];
            HPD_OUT <= (state == edid_seq_pkg::S_NORMAL) ? {N{tmp_s[2]}} : '0;
            REJECT_LED <= (state == edid_seq_pkg::S_HALT);
            NORMAL <= (state == edid_seq_pkg::S_NORMAL);
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);

    chk_normal_stays: assert property (state == edid_seq_pkg::S_NORMAL |=> state == edid_seq_pkg::S_NORMAL && !ID_MUX_EN)
        else $error("left normal mode or reopened identification path");
    chk_halt_sticky: assert property (state == edid_seq_pkg::S_HALT |=> state == edid_seq_pkg::S_HALT)
        else $error("halt was left");
    chk_reject_led: assert property (state == edid_seq_pkg::S_HALT |=> REJECT_LED && !VIDEO_EN)
        else $error("reject indicator not lit");
    chk_prog_route: assert property (state == edid_seq_pkg::S_WR_START && cmd_valid |->
        ID_MUX_SEL == ch && MODE_PROG[ch] && WP_OPEN[ch] && $onehot(WP_OPEN))
        else $error("channel not routed for programming");
    chk_advance_ok: assert property (state == edid_seq_pkg::S_NEXT |-> !mism && $past(state) == edid_seq_pkg::S_RD_STOP)
        else $error("advanced without clean verify");
    chk_mismatch_retry: assert property (state == edid_seq_pkg::S_RD_STOP && done && verify && mism
        |=> state == edid_seq_pkg::S_WR_START && ch == $past(ch))
        else $error("mismatch did not reprogram channel");
    chk_normal_locked: assert property (state == edid_seq_pkg::S_NORMAL |-> WP_OPEN == '0 && MODE_PROG == '0)
        else $error("write protect open in normal mode");
    chk_video_follow: assert property (state == edid_seq_pkg::S_NORMAL && sel_ok |=> CHAN_SEL == $past(SEL_IN))
        else $error("video mux did not follow selection");
    chk_hpd_gate: assert property (state != edid_seq_pkg::S_NORMAL |=> HPD_OUT == '0)
        else $error("hot-plug passed outside normal mode");
    chk_tamper_iso: assert property ($rose(tmp_s[0] || tmp_s[1]) |=> !VIDEO_EN [*3])
        else $error("video not isolated after tamper");
    chk_boot_chan: assert property (state != edid_seq_pkg::S_NORMAL |-> CHAN_SEL == '0)
        else $error("selection not first channel before normal");
endmodule

// ### common/edid_seq_params.svh
`ifndef EDID_SEQ_PARAMS_SVH
`define EDID_SEQ_PARAMS_SVH
// Clock period of CLK
`define CLK_PERIOD_NS 5
// Quarter of one I2C bit time (100 kHz bus)
`define I2C_QUARTER_NS 2500
`define I2C_QUARTER_CYC ((`I2C_QUARTER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Least EEPROM internal write time per byte
`define EE_WRITE_NS 5000000
`define EE_WRITE_CYC ((`EE_WRITE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Identification block size and channel count
`define ID_BYTES 128
`define CHANNELS 4
// I2C device addresses of the identification memory
`define ID_DEV_WR 8'ha0
`define ID_DEV_RD 8'ha1
`define ID_START_OFS 8'h00
// Header pattern: first and last header bytes are zero, the rest all ones
`define HDR_LEN 8
`define HDR_EDGE 8'h00
`define HDR_MID 8'hff
`endif

// ### common/edid_seq_pkg.sv
package edid_seq_pkg;
    // Bus operations of the I2C engine
    typedef enum logic [1:0] {OP_START, OP_STOP, OP_WRITE, OP_READ} i2c_op_t;
    // One engine command: operation, byte to send, acknowledge a read byte
    typedef struct packed {
        i2c_op_t op;
        logic [7:0] data;
        logic ack;
    } i2c_cmd_t;
    // Sequencer states
    typedef enum {
        S_RD_START, S_RD_DEVW, S_RD_OFS, S_RD_RESTART, S_RD_DEVR, S_RD_DATA,
        S_RD_STOP, S_CHECK, S_HALT, S_WR_START, S_WR_DEVW, S_WR_OFS,
        S_WR_DATA, S_WR_STOP, S_WR_WAIT, S_NEXT, S_NORMAL
    } seq_state_t;
endpackage

// ### hw/i2c_op_engine.sv
`timescale 1ns/100ps
`include "edid_seq_params.svh"
module i2c_op_engine #(
    parameter int QUARTER = `I2C_QUARTER_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire edid_seq_pkg::i2c_cmd_t cmd,
    input wire logic cmd_valid,
    output logic cmd_ready,
    output logic done,
    output logic [7:0] rdata,
    output logic nack,
    input wire logic sda_i,
    output logic sda_oe,
    output logic scl_oe
);
    initial begin
        if (QUARTER < 1) $error("QUARTER must be at least one cycle");
    end

    localparam int QW = $clog2(QUARTER + 1);
    logic busy;
    edid_seq_pkg::i2c_op_t op;
    logic [1:0] phase;
    logic [QW-1:0] cnt;
    logic [3:0] bitn;
    logic [8:0] shreg;
    logic [8:0] rx;
    logic sda_m, sda_s;
    logic scl_lvl, sda_lvl, q_end, last_bit, is_bit;
    logic hold, fin;

    // Bus levels per phase: start and stop move SDA while SCL is high
    assign is_bit = (op == edid_seq_pkg::OP_WRITE) || (op == edid_seq_pkg::OP_READ);
    assign scl_lvl = ~busy ? ~hold :
                     (op == edid_seq_pkg::OP_START) ? (phase != 2'd3) :
                     (op == edid_seq_pkg::OP_STOP) ? (phase != 2'd0) :
                     (phase == 2'd1) || (phase == 2'd2);
    assign sda_lvl = ~busy ? 1'b1 :
                     (op == edid_seq_pkg::OP_START) ? (phase < 2'd2) :
                     (op == edid_seq_pkg::OP_STOP) ? (phase == 2'd3) : shreg[8];
    assign q_end = busy && (cnt == QW'(QUARTER - 1));
    assign last_bit = ~is_bit || (bitn == 4'd8);
    assign cmd_ready = ~busy;
    assign rdata = rx[8:1];
    assign nack = rx[0];
    assign fin = q_end && (phase == 2'd3) && last_bit;

    // Clock kept low between ops so the idle cycle adds no clock pulse; a stop releases it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) hold <= 1'b0;
        else if (fin) hold <= (op != edid_seq_pkg::OP_STOP);
    end

    // Data line synchroniser
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sda_m <= 1'b1;
            sda_s <= 1'b1;
        end else begin
            sda_m <= sda_i;
            sda_s <= sda_m;
        end
    end

    // Open-drain drivers pull low when the level is zero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_oe <= 1'b0;
            sda_oe <= 1'b0;
        end else begin
            scl_oe <= ~scl_lvl;
            sda_oe <= ~sda_lvl;
        end
    end

    // Phase and bit sequencing; nine bit slots per byte, ack last
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busy <= 1'b0;
            op <= edid_seq_pkg::OP_STOP;
            phase <= 2'd0;
            cnt <= '0;
            bitn <= 4'd0;
            shreg <= 9'h1ff;
            rx <= 9'h000;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (!busy) begin
                if (cmd_valid) begin
                    busy <= 1'b1;
                    op <= cmd.op;
                    phase <= 2'd0;
                    cnt <= '0;
                    bitn <= 4'd0;
                    shreg <= (cmd.op == edid_seq_pkg::OP_READ) ? {8'hff, ~cmd.ack} : {cmd.data, 1'b1};
                end
            end else if (!q_end) begin
                cnt <= cnt + QW'(1);
            end else begin
                cnt <= '0;
                phase <= phase + 2'd1;
                if (phase == 2'd2) rx <= {rx[7:0], sda_s};
                if (phase == 2'd3) begin
                    if (last_bit) begin
                        busy <= 1'b0;
                        done <= 1'b1;
                    end else begin
                        bitn <= bitn + 4'd1;
                        shreg <= {shreg[7:0], 1'b1};
                    end
                end
            end
        end
    end
endmodule

// ### verif/edid_far_end.sv
`timescale 1ns/100ps
`include "edid_seq_params.svh"
module edid_far_end #(
    parameter int N = 4,
    parameter int BYTES = 16
) (
    input wire logic scl,
    input wire logic sda,
    input wire logic mux_en,
    input wire logic to_display,
    input wire logic [$clog2(N)-1:0] sel,
    input wire logic [N-1:0] mode,
    input wire logic [N-1:0] wp_open,
    input wire logic spoil,
    output logic pull
);
    logic [7:0] disp [BYTES];
    logic [7:0] ee [N][BYTES];
    int nwr [N];
    int nstart;
    int bn;
    int nb;
    int tgt;
    logic [7:0] sh, dat, ptr;
    logic active, fresh, rd, rd_end, spoiled;
    // Bus released and memories idle at power-up
    initial begin
        pull = 0;
        active = 0;
        fresh = 0;
        nstart = 0;
        spoiled = 0;
        ptr = 8'h00;
    end
    // Start condition: data falls while the clock is high
    always @(negedge sda) begin
        if (scl === 1'b1) begin
            active = 1;
            fresh = 1;
            bn = 0;
            nb = 0;
            rd = 0;
            rd_end = 0;
            nstart++;
        end
    end
    // Stop condition: data rises while the clock is high
    always @(posedge sda) begin
        if (scl === 1'b1) begin
            active = 0;
            pull = 0;
        end
    end
    // Bits are taken while the clock is high; a high ninth bit ends a read
    always @(posedge scl) begin
        if (active && bn < 8)
            sh = {sh[6:0], sda};
        else if (active && rd && sda)
            rd_end = 1;
    end
    // Slave drive changes only while the clock is low
    always @(negedge scl) begin
        if (active && fresh) begin
            fresh = 0;
        end else if (active && bn == 7) begin
            pull = 0;
            bn = 8;
            if (nb == 0) begin
                tgt = to_display ? N : (mux_en && mode[sel]) ? int'(sel) : -1;
                pull = (tgt >= 0) && ({sh[7:1], 1'b0} == `ID_DEV_WR);
                rd = pull && sh[0];
            end else if (!rd && nb == 1 && tgt >= 0) begin
                ptr = sh;
                pull = 1;
            end else if (!rd && tgt >= 0) begin
                if (tgt < N && wp_open[tgt]) begin
                    ee[tgt][ptr] = sh ^ {7'h00, spoil && !spoiled && tgt == 1};
                    spoiled = spoiled || (spoil && tgt == 1);
                    nwr[tgt]++;
                end
                ptr++;
                pull = 1;
            end
        end else if (active && bn == 8) begin
            pull = 0;
            bn = 0;
            nb++;
            if (rd && !rd_end) begin
                dat = (tgt == N) ? disp[ptr] : ee[tgt][ptr];
                ptr++;
                pull = !dat[7];
            end
        end else if (active) begin
            bn++;
            if (rd && !rd_end)
                pull = !dat[7-bn];
        end
    end
endmodule

// ### verif/test_edid_seq.sv
`timescale 1ns/100ps
module test_edid_seq;
    localparam int N = 4;
    localparam int BYTES = 16;
    localparam int LIMIT = 90000;
    logic CLK, RST_N, SEL_VALID, HPD_I, TAMPER_I, SELFTEST_FAIL_I, spoil, pull;
    logic SDA_OE, SCL_OE, ID_MUX_EN, ID_MUX_TO_DISPLAY, VIDEO_EN, REJECT_LED, NORMAL;
    logic [1:0] SEL_IN, CHAN_SEL, ID_MUX_SEL, last_sel;
    logic [N-1:0] MODE_PROG, WP_OPEN, HPD_OUT, exp_rt;
    int n_errors = 0;
    int compares = 0;
    int cycles = 0;
    int s;
    // Open-drain wires with pull-ups
    wire logic scl = !SCL_OE;
    wire logic sda = !(SDA_OE || pull);
    edid_seq #(.N(N), .BYTES(BYTES), .WR_WAIT(4), .QUARTER(2)) edid_seq_i (
        .CLK(CLK), .RST_N(RST_N), .SDA_I(sda), .SDA_OE(SDA_OE), .SCL_OE(SCL_OE), .ID_MUX_EN(ID_MUX_EN),
        .ID_MUX_TO_DISPLAY(ID_MUX_TO_DISPLAY), .ID_MUX_SEL(ID_MUX_SEL), .MODE_PROG(MODE_PROG), .WP_OPEN(WP_OPEN),
        .SEL_IN(SEL_IN), .SEL_VALID(SEL_VALID), .CHAN_SEL(CHAN_SEL), .VIDEO_EN(VIDEO_EN), .HPD_I(HPD_I),
        .HPD_OUT(HPD_OUT), .TAMPER_I(TAMPER_I), .SELFTEST_FAIL_I(SELFTEST_FAIL_I), .REJECT_LED(REJECT_LED),
        .NORMAL(NORMAL));
    edid_far_end #(.N(N), .BYTES(BYTES)) edid_far_end_i (
        .scl(scl), .sda(sda), .mux_en(ID_MUX_EN), .to_display(ID_MUX_TO_DISPLAY), .sel(ID_MUX_SEL),
        .mode(MODE_PROG), .wp_open(WP_OPEN), .spoil(spoil), .pull(pull));
    // Clock at 200 MHz
    initial begin
        CLK = 0;
        forever #2.5 CLK = !CLK;
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic finish_test();
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Cuts a hang short
    always @(posedge CLK) begin
        cycles++;
        if (cycles == LIMIT) begin
            n_errors++;
            finish_test();
        end
    end
    // Watches routing and user outputs while the sequencer owns the identification path
    always @(posedge CLK) begin
        #1;
        if (RST_N && ID_MUX_EN) begin
            chk("user outputs", 0, {CHAN_SEL, HPD_OUT, VIDEO_EN});
            if (MODE_PROG != 0) begin
                exp_rt = 4'(1 << ID_MUX_SEL);
                chk("routing", {1'b0, exp_rt, exp_rt}, {ID_MUX_TO_DISPLAY, MODE_PROG, WP_OPEN});
                chk("channel order", 1, ID_MUX_SEL >= last_sel);
                last_sel = ID_MUX_SEL;
            end else begin
                chk("protect", 0, WP_OPEN);
            end
        end
    end
    // Loads a display block (0 valid, 1 bad header, 2 bad checksum) and resets
    task automatic do_reset(input int bad, input logic spoil_v);
        logic [7:0] sum;
        sum = 8'h00;
        RST_N <= 0;
        spoil <= spoil_v;
        {SEL_IN, SEL_VALID, HPD_I, TAMPER_I, SELFTEST_FAIL_I} <= 6'h3c;
        for (int i = 0; i < BYTES; i++) begin
            edid_far_end_i.disp[i] = (i == 0 || i == 7) ? 8'h00 : (i < 7) ? 8'hff : 8'h10 + 8'(i);
            if (i == BYTES - 1)
                edid_far_end_i.disp[i] = -sum;
            sum += edid_far_end_i.disp[i];
            for (int c = 0; c < N; c++)
                edid_far_end_i.ee[c][i] = 8'h00;
        end
        if (bad == 1)
            edid_far_end_i.disp[1] = 8'hfe;
        if (bad != 0)
            edid_far_end_i.disp[BYTES-1] += 8'h01;
        for (int c = 0; c < N; c++)
            edid_far_end_i.nwr[c] = 0;
        edid_far_end_i.nstart = 0;
        edid_far_end_i.spoiled = 0;
        last_sel = 2'h0;
        repeat (10) @(posedge CLK);
        RST_N <= 1;
    endtask
    task automatic wait_end();
        for (int i = 0; i < 40000 && NORMAL !== 1'b1 && REJECT_LED !== 1'b1; i++)
            @(posedge CLK);
        #1;
    endtask
    // Full programming with one spoiled write on channel 1
    task automatic test_program();
        do_reset(0, 1'b1);
        wait_end();
        chk("normal", 1, NORMAL);
        chk("paths closed", 0, {ID_MUX_EN, MODE_PROG, WP_OPEN});
        chk("video on", 1, VIDEO_EN);
        for (int c = 0; c < N; c++) begin
            chk("writes", (c == 1) ? 2 * BYTES : BYTES, edid_far_end_i.nwr[c]);
            for (int i = 0; i < BYTES; i++)
                chk("copy", edid_far_end_i.disp[i], edid_far_end_i.ee[c][i]);
        end
    endtask
    // Every selection is taken; an unqualified one is not
    task automatic test_select();
        for (int k = N - 1; k >= 0; k--) begin
            @(posedge CLK);
            SEL_IN <= 2'(k);
            SEL_VALID <= 1;
            @(posedge CLK);
            SEL_IN <= 2'(k) ^ 2'h1;
            SEL_VALID <= 0;
            @(posedge CLK);
            #1;
            chk("selection", k, CHAN_SEL);
        end
    endtask
    task automatic test_hpd();
        for (int v = 0; v < 2; v++) begin
            @(posedge CLK);
            HPD_I <= v[0];
            repeat (4) @(posedge CLK);
            #1;
            chk("hot plug", {N{v[0]}}, HPD_OUT);
        end
    endtask
    // No further capture after a display change
    task automatic test_ignore();
        s = edid_far_end_i.nstart;
        edid_far_end_i.disp[8] = 8'h55;
        repeat (3000) @(posedge CLK);
        chk("starts", s, edid_far_end_i.nstart);
        chk("kept copy", 8'h18, edid_far_end_i.ee[0][8]);
    endtask
    task automatic test_isolate();
        @(posedge CLK);
        SELFTEST_FAIL_I <= 1;
        @(posedge CLK);
        #1;
        chk("video early", 1, VIDEO_EN);
        repeat (2) @(posedge CLK);
        #1;
        chk("video off", 0, VIDEO_EN);
        @(posedge CLK);
        SELFTEST_FAIL_I <= 0;
        repeat (10) @(posedge CLK);
        #1;
        chk("video latched", 0, VIDEO_EN);
    endtask
    // Tamper pulse during capture keeps video isolated after programming
    task automatic test_tamper();
        do_reset(0, 1'b0);
        repeat (100) @(posedge CLK);
        TAMPER_I <= 1;
        repeat (2) @(posedge CLK);
        TAMPER_I <= 0;
        wait_end();
        chk("normal", 1, NORMAL);
        chk("video off", 0, VIDEO_EN);
        for (int c = 0; c < N; c++)
            chk("writes", BYTES, edid_far_end_i.nwr[c]);
    endtask
    task automatic test_reject();
        for (int k = 1; k < 3; k++) begin
            do_reset(k, 1'b0);
            wait_end();
            chk("reject", 1, REJECT_LED);
            s = edid_far_end_i.nstart;
            repeat (2000) @(posedge CLK);
            #1;
            chk("halt", 4'h8, {REJECT_LED, NORMAL, VIDEO_EN, ID_MUX_EN});
            chk("halt starts", s, edid_far_end_i.nstart);
            chk("no writes", 0, edid_far_end_i.nwr[0]);
        end
    endtask
    initial begin
        test_program();
        test_select();
        test_hpd();
        test_ignore();
        test_isolate();
        test_tamper();
        test_reject();
        finish_test();
    end
endmodule
